// [pkg/sideband_cmd_pkg.sv]
// Package: constants and types for the sideband command responder
package sideband_cmd_pkg;

  localparam int TAG_W        = 8;
  localparam int TYPE_W       = 8;
  localparam int CODE_W       = 16;
  localparam int DATA_W       = 32;
  localparam int CLOCK_HZ     = 20_000_000;

  localparam logic [TAG_W-1:0]  TAG_NOTICE    = 8'h00;
  localparam logic [CODE_W-1:0] RESP_OK       = 16'h0000;
  localparam logic [CODE_W-1:0] RESP_FAILED   = 16'h0001;
  localparam logic [CODE_W-1:0] RESP_UNAVAIL  = 16'h0002;
  localparam logic [CODE_W-1:0] RESP_UNSUPP   = 16'h0003;
  localparam logic [CODE_W-1:0] RESP_DELAYED  = 16'h0004;
  localparam logic [CODE_W-1:0] REASON_NONE   = 16'h0000;
  localparam logic [CODE_W-1:0] REASON_UNKNOWN = 16'h7FFF;
  localparam logic [CODE_W-1:0] REASON_DELAYED = 16'h0010;
  localparam logic [CODE_W-1:0] REASON_NO_CMD  = 16'h0011;
  localparam logic [CODE_W-1:0] REASON_TIMEOUT = 16'h0012;

  localparam logic [TYPE_W-1:0] CMD_CLEAR_INIT  = 8'h00;
  localparam logic [TYPE_W-1:0] CMD_LINK_STATUS = 8'h0A;
  localparam logic [TYPE_W-1:0] CMD_MAX_STD     = 8'h60;
  localparam logic [TYPE_W-1:0] CMD_VENDOR      = 8'h50;

  // Intervals in milliseconds; counts follow from the clock rate
  localparam int NORMAL_EXEC_MS       = 50;
  localparam int ASYNC_NOT_READY_MS   = 2000;
  localparam int DELAYED_LIMIT_MS     = 60000;
  localparam int NORMAL_EXEC_CYC      = NORMAL_EXEC_MS * (CLOCK_HZ / 1000);
  localparam int ASYNC_NOT_READY_CYC  = ASYNC_NOT_READY_MS * (CLOCK_HZ / 1000);
  localparam longint DELAYED_LIMIT_CYC = longint'(DELAYED_LIMIT_MS) * longint'(CLOCK_HZ / 1000);
  localparam logic [15:0] POLL_HINT_MS = 16'h0064;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_EXEC    = 4'b0010,
    ST_RESPOND = 4'b0100,
    ST_POST    = 4'b1000
  } state_type;

endpackage : sideband_cmd_pkg

// [rtl/interval_timer.sv]
// Down-counting deadline timer used for the command intervals
module interval_timer (
  clock,
  rst_n,
  load,
  stop,
  limit,
  expired,
  running
);
  input  wire logic        clock;
  input  wire logic        rst_n;
  input  wire logic        load;
  input  wire logic        stop;
  input  wire logic [31:0] limit;
  output logic             expired;
  output logic             running;

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_running;
  logic        next_expired;

  always_comb begin
    next_count   = count;
    next_running = running;
    next_expired = 1'b0;
    if (load) begin
      next_count   = limit;
      next_running = 1'b1;
    end else if (stop) begin
      next_running = 1'b0;
    end else if (running) begin
      if (count <= 32'h00000001) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_count = count - 32'h00000001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 32'h00000000;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      expired <= next_expired;
    end
  end

endmodule : interval_timer

// [rtl/sideband_cmd_responder.sv]
// Command acceptance, retry, poll and response logic of one sideband channel
module sideband_cmd_responder
  import sideband_cmd_pkg::*;
#(
  parameter int unsigned normal_exec_cycles     = NORMAL_EXEC_CYC,
  parameter int unsigned async_not_ready_cycles = ASYNC_NOT_READY_CYC,
  parameter int unsigned delayed_limit_cycles   = 32'(DELAYED_LIMIT_CYC)
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic [TAG_W-1:0]       cmd_tag,
  input  wire logic [TYPE_W-1:0]      cmd_type,
  input  wire logic                   cmd_poll,
  input  wire logic [DATA_W-1:0]      cmd_data,
  input  wire logic                   cmd_supported,
  input  wire logic                   cmd_early_ok,
  output logic                        op_start,
  output logic [TYPE_W-1:0]           op_type,
  output logic [DATA_W-1:0]           op_data,
  input  wire logic                   op_busy_other,
  input  wire logic                   op_done,
  input  wire logic                   op_fail,
  input  wire logic [DATA_W-1:0]      op_result,
  input  wire logic [DATA_W-1:0]      link_status,
  output logic                        resp_valid,
  input  wire logic                   resp_ready,
  output logic [TAG_W-1:0]            resp_tag,
  output logic [TYPE_W-1:0]           resp_type,
  output logic [CODE_W-1:0]           resp_code,
  output logic [CODE_W-1:0]           resp_reason,
  output logic [DATA_W-1:0]           resp_data,
  output logic [15:0]                 resp_poll_hint,
  input  wire logic                   event_valid,
  input  wire logic [CODE_W-1:0]      event_code,
  output logic                        notice_valid,
  input  wire logic                   notice_ready,
  output logic [TAG_W-1:0]            notice_tag,
  output logic [CODE_W-1:0]           notice_code,
  output logic                        initial_state,
  input  wire logic                   clear_initial
);

  // ==========================================================
  // Command classification
  // ==========================================================
  function automatic logic type_known(input logic [TYPE_W-1:0] t, input logic sup);
    type_known = sup && ((t < CMD_MAX_STD) || (t == CMD_VENDOR));
  endfunction : type_known

  state_type          state;
  state_type          next_state;
  logic               tag_valid;
  logic               next_tag_valid;
  logic [TAG_W-1:0]   last_tag;
  logic [TAG_W-1:0]   next_last_tag;
  logic [TYPE_W-1:0]  last_type;
  logic [TYPE_W-1:0]  next_last_type;
  logic               delayed_mode;
  logic               next_delayed_mode;
  logic               early_sent;
  logic               next_early_sent;
  logic               next_initial_state;
  logic [TAG_W-1:0]   next_resp_tag;
  logic [TYPE_W-1:0]  next_resp_type;
  logic [CODE_W-1:0]  next_resp_code;
  logic [CODE_W-1:0]  next_resp_reason;
  logic [DATA_W-1:0]  next_resp_data;
  logic [15:0]        next_poll_hint;
  logic               next_resp_valid;
  logic               next_op_start;
  logic [TYPE_W-1:0]  next_op_type;
  logic [DATA_W-1:0]  next_op_data;
  logic               timer_load;
  logic               timer_stop;
  logic [31:0]        timer_limit;
  logic               timer_expired;
  logic               timer_running;

  logic is_retry;
  logic is_poll;
  logic take;

  assign is_retry = tag_valid && (cmd_tag == last_tag) && !cmd_poll;
  assign is_poll  = tag_valid && (cmd_tag == last_tag) && cmd_poll;
  // Retries, polls and link-status queries are taken even while busy
  assign cmd_ready = !resp_valid && (state == ST_IDLE || state == ST_POST || is_poll || is_retry
                     || cmd_type == CMD_LINK_STATUS);
  assign take = cmd_valid && cmd_ready;

  interval_timer u_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (timer_load),
    .stop    (timer_stop),
    .limit   (timer_limit),
    .expired (timer_expired),
    .running (timer_running)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    next_state         = state;
    next_tag_valid     = tag_valid;
    next_last_tag      = last_tag;
    next_last_type     = last_type;
    next_delayed_mode  = delayed_mode;
    next_early_sent    = early_sent;
    next_initial_state = initial_state;
    next_resp_tag      = resp_tag;
    next_resp_type     = resp_type;
    next_resp_code     = resp_code;
    next_resp_reason   = resp_reason;
    next_resp_data     = resp_data;
    next_poll_hint     = resp_poll_hint;
    next_resp_valid    = resp_valid && !resp_ready;
    next_op_start      = 1'b0;
    next_op_type       = op_type;
    next_op_data       = op_data;
    timer_load         = 1'b0;
    timer_stop         = 1'b0;
    timer_limit        = normal_exec_cycles;

    if (clear_initial) begin
      next_initial_state = 1'b0;
    end

    case (state)
      ST_IDLE, ST_POST: begin
        if (take) begin
          next_resp_valid = 1'b1;
          next_resp_tag   = cmd_tag;
          next_resp_type  = cmd_type;
          if (is_retry) begin
            // Stored response is replayed untouched
          end else if (is_poll) begin
            if (state == ST_POST || !delayed_mode) begin
              next_resp_code   = RESP_FAILED;
              next_resp_reason = REASON_NO_CMD;
            end
          end else if (cmd_type == CMD_LINK_STATUS) begin
            next_tag_valid   = 1'b1;
            next_last_tag    = cmd_tag;
            next_last_type   = cmd_type;
            next_resp_code   = RESP_OK;
            next_resp_reason = REASON_NONE;
            next_resp_data   = link_status;
          end else if (!type_known(cmd_type, cmd_supported)) begin
            next_tag_valid   = 1'b1;
            next_last_tag    = cmd_tag;
            next_last_type   = cmd_type;
            next_resp_code   = RESP_UNSUPP;
            next_resp_reason = REASON_UNKNOWN;
          end else if (op_busy_other || state == ST_POST) begin
            // Previous early-answered action still running keeps order
            next_tag_valid   = 1'b1;
            next_last_tag    = cmd_tag;
            next_last_type   = cmd_type;
            next_resp_code   = RESP_UNAVAIL;
            next_resp_reason = REASON_NONE;
          end else begin
            next_tag_valid    = 1'b1;
            next_last_tag     = cmd_tag;
            next_last_type    = cmd_type;
            next_op_start     = 1'b1;
            next_op_type      = cmd_type;
            next_op_data      = cmd_data;
            next_delayed_mode = 1'b0;
            timer_load        = 1'b1;
            if (cmd_early_ok) begin
              // Answer now, action completes afterwards
              next_resp_code   = RESP_OK;
              next_resp_reason = REASON_NONE;
              next_resp_data   = op_result;
              next_early_sent  = 1'b1;
              timer_limit      = async_not_ready_cycles;
              next_state       = ST_POST;
            end else begin
              next_resp_valid = 1'b0;
              next_early_sent = 1'b0;
              next_state      = ST_EXEC;
            end
          end
        end else if (state == ST_POST && (op_done || op_fail || timer_expired)) begin
          timer_stop = 1'b1;
          next_state = ST_IDLE;
          if (op_fail || timer_expired) begin
            next_initial_state = 1'b1;
            next_tag_valid     = 1'b0;
          end
        end
      end
      ST_EXEC: begin
        if (take && is_poll) begin
          next_resp_valid  = 1'b1;
          next_resp_tag    = cmd_tag;
          next_resp_type   = last_type;
          next_resp_code   = RESP_DELAYED;
          next_resp_reason = REASON_DELAYED;
          next_poll_hint   = POLL_HINT_MS;
        end else if (take) begin
          next_resp_valid  = 1'b1;
          next_resp_tag    = cmd_tag;
          next_resp_type   = cmd_type;
          if (cmd_type == CMD_LINK_STATUS) begin
            next_resp_code   = RESP_OK;
            next_resp_reason = REASON_NONE;
            next_resp_data   = link_status;
          end else begin
            next_resp_code   = RESP_UNAVAIL;
            next_resp_reason = REASON_NONE;
          end
        end else if (op_done || op_fail) begin
          timer_stop     = 1'b1;
          next_resp_data = op_result;
          next_resp_code = op_fail ? RESP_FAILED : RESP_OK;
          next_resp_reason = REASON_NONE;
          next_resp_tag  = last_tag;
          next_resp_type = last_type;
          // After a delayed answer the result waits for the poll
          next_resp_valid = !delayed_mode;
          next_state     = ST_IDLE;
        end else if (timer_expired && !delayed_mode) begin
          next_delayed_mode = 1'b1;
          timer_load        = 1'b1;
          timer_limit       = delayed_limit_cycles;
          next_resp_valid   = 1'b1;
          next_resp_tag     = last_tag;
          next_resp_type    = last_type;
          next_resp_code    = RESP_DELAYED;
          next_resp_reason  = REASON_DELAYED;
          next_poll_hint    = POLL_HINT_MS;
        end else if (timer_expired) begin
          next_resp_code     = RESP_FAILED;
          next_resp_reason   = REASON_TIMEOUT;
          next_initial_state = 1'b1;
          next_tag_valid     = 1'b0;
          next_delayed_mode  = 1'b0;
          next_state         = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Storage of resp_* is the held copy for retries
    if (initial_state && !clear_initial) begin
      next_tag_valid = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      tag_valid      <= 1'b0;
      last_tag       <= 8'h00;
      last_type      <= 8'h00;
      delayed_mode   <= 1'b0;
      early_sent     <= 1'b0;
      initial_state  <= 1'b1;
      resp_valid     <= 1'b0;
      resp_tag       <= 8'h00;
      resp_type      <= 8'h00;
      resp_code      <= 16'h0000;
      resp_reason    <= 16'h0000;
      resp_data      <= 32'h00000000;
      resp_poll_hint <= 16'h0000;
      op_start       <= 1'b0;
      op_type        <= 8'h00;
      op_data        <= 32'h00000000;
    end else begin
      state          <= next_state;
      tag_valid      <= next_tag_valid;
      last_tag       <= next_last_tag;
      last_type      <= next_last_type;
      delayed_mode   <= next_delayed_mode;
      early_sent     <= next_early_sent;
      initial_state  <= next_initial_state;
      resp_valid     <= next_resp_valid;
      resp_tag       <= next_resp_tag;
      resp_type      <= next_resp_type;
      resp_code      <= next_resp_code;
      resp_reason    <= next_resp_reason;
      resp_data      <= next_resp_data;
      resp_poll_hint <= next_poll_hint;
      op_start       <= next_op_start;
      op_type        <= next_op_type;
      op_data        <= next_op_data;
    end
  end

  // ==========================================================
  // Event notices, independent of responses
  // ==========================================================
  logic              next_notice_valid;
  logic [CODE_W-1:0] next_notice_code;

  always_comb begin
    next_notice_valid = notice_valid && !notice_ready;
    next_notice_code  = notice_code;
    // No ordering against responses is kept
    if (event_valid && !next_notice_valid) begin
      next_notice_valid = 1'b1;
      next_notice_code  = event_code;
    end
  end

  assign notice_tag = TAG_NOTICE;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      notice_valid <= 1'b0;
      notice_code  <= 16'h0000;
    end else begin
      notice_valid <= next_notice_valid;
      notice_code  <= next_notice_code;
    end
  end

endmodule : sideband_cmd_responder

// [dv/sideband_cmd_asserts.sv]
// Port-level assertions for the sideband command responder
module sideband_cmd_asserts
  import sideband_cmd_pkg::*;
#(
  parameter int unsigned normal_exec_cycles = NORMAL_EXEC_CYC
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [TAG_W-1:0]  cmd_tag,
  input wire logic [TYPE_W-1:0] cmd_type,
  input wire logic              cmd_poll,
  input wire logic              cmd_supported,
  input wire logic              op_start,
  input wire logic              op_done,
  input wire logic              op_fail,
  input wire logic              op_busy_other,
  input wire logic              resp_valid,
  input wire logic              resp_ready,
  input wire logic [TAG_W-1:0]  resp_tag,
  input wire logic [CODE_W-1:0] resp_code,
  input wire logic [CODE_W-1:0] resp_reason,
  input wire logic              notice_valid,
  input wire logic [TAG_W-1:0]  notice_tag,
  input wire logic              initial_state
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RESP_BOUND = int'(normal_exec_cycles) + 3;
  logic             take, fresh, retry, pending, post_ok, init_d, known;
  logic [TAG_W-1:0] last_tag;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  assign take  = cmd_valid && cmd_ready;
  assign retry = take && !cmd_poll && !pending && !initial_state && known && cmd_tag == last_tag;
  assign fresh = take && !cmd_poll && !pending && !initial_state && !(known && cmd_tag == last_tag);
  // ====================
  // Tag memory and pending action; polls while pending must not move the tag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_tag <= '0;
      known    <= 1'h0;
      pending  <= 1'h0;
      post_ok  <= 1'h0;
      init_d   <= 1'h1;
    end else begin
      init_d <= initial_state;
      known  <= (known || take) && !initial_state;
      if (take && !pending) begin
        last_tag <= cmd_tag;
      end
      if (op_start) begin
        pending <= 1'h1;
      end else if (op_done || op_fail || (initial_state && !init_d)) begin
        pending <= 1'h0;
      end
      post_ok <= pending && (post_ok || (resp_valid && resp_ready && resp_code == RESP_OK));
    end
  end
  // ====================
  // Assertions
  a_notice_tag_zero: assert property (notice_valid |-> notice_tag == TAG_NOTICE)
    else $error("notice tag not zero");
  a_refuse_while_resp: assert property (resp_valid |-> !cmd_ready)
    else $error("command taken while response pending");
  a_resp_holds: assert property (resp_valid && !resp_ready |=>
    resp_valid && $stable(resp_tag) && $stable(resp_code))
    else $error("response changed before handshake");
  a_tag_echo: assert property ($rose(resp_valid) && !$past(take && pending) |-> resp_tag == last_tag)
    else $error("response tag differs from command tag");
  a_unsupp_answer: assert property (fresh && !op_busy_other && cmd_type != CMD_LINK_STATUS &&
    (!cmd_supported || cmd_type >= CMD_MAX_STD) |=> resp_valid && resp_code == RESP_UNSUPP &&
    resp_reason == REASON_UNKNOWN)
    else $error("unknown command not answered unsupported");
  a_unavail_answer: assert property (fresh && op_busy_other && cmd_supported && cmd_type < CMD_MAX_STD &&
    cmd_type != CMD_LINK_STATUS |=> resp_valid && resp_code == RESP_UNAVAIL)
    else $error("blocked command not answered unavailable");
  a_retry_no_start: assert property (retry |=> !op_start)
    else $error("retried command executed again");
  a_resp_in_time: assert property (op_start |-> ##[0:RESP_BOUND] resp_valid)
    else $error("no response within normal interval");
  a_fail_initial: assert property (op_fail && post_ok |-> ##[1:3] initial_state)
    else $error("failed early action left channel active");
endmodule : sideband_cmd_asserts

bind sideband_cmd_responder sideband_cmd_asserts #(.normal_exec_cycles(normal_exec_cycles)) sideband_cmd_asserts_i (.*);

// [dv/mgmt_host_model.sv]
// Management host model: one command outstanding, response collected by handshake
module mgmt_host_model
  import sideband_cmd_pkg::*;
(
  input  wire logic              clock,
  output logic                   cmd_valid,
  input  wire logic              cmd_ready,
  output logic [TAG_W-1:0]       cmd_tag,
  output logic [TYPE_W-1:0]      cmd_type,
  output logic                   cmd_poll,
  output logic [DATA_W-1:0]      cmd_data,
  input  wire logic              resp_valid,
  output logic                   resp_ready,
  input  wire logic [TAG_W-1:0]  resp_tag,
  input  wire logic [CODE_W-1:0] resp_code,
  input  wire logic [CODE_W-1:0] resp_reason,
  input  wire logic [DATA_W-1:0] resp_data,
  input  wire logic [15:0]       resp_poll_hint
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid  = 1'h0;
    cmd_tag    = 8'hFF;
    cmd_type   = 8'hFF;
    cmd_poll   = 1'h1;
    cmd_data   = 32'hFFFF_FFFF;
    resp_ready = 1'h0;
  end
  // ====================
  // Caller picks the tag: fresh for new commands, same for retry and poll
  task automatic transact(input logic [TAG_W-1:0] tag, input logic [TYPE_W-1:0] kind, input logic poll,
                          input int stall, output logic ok, output logic [TAG_W-1:0] tag_seen,
                          output logic [CODE_W-1:0] code, output logic [CODE_W-1:0] reason,
                          output logic [DATA_W-1:0] data, output logic [15:0] hint);
    int i;
    ok = 1'h0;
    @(negedge clock);
    cmd_valid <= 1'h1;
    cmd_tag   <= tag;
    cmd_type  <= kind;
    cmd_poll  <= poll;
    cmd_data  <= {tag, kind, tag, kind};
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (cmd_ready === 1'h1) break;
    end
    if (i == 200) return;
    @(negedge clock);
    // Released fields go inverse so a stale sample cannot match
    cmd_valid <= 1'h0;
    cmd_tag   <= ~tag;
    cmd_type  <= ~kind;
    cmd_poll  <= ~poll;
    cmd_data  <= ~{tag, kind, tag, kind};
    // Timeout well above the normal interval
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      #1;
      if (resp_valid === 1'h1) break;
    end
    if (i == 200) return;
    repeat (stall + 1) @(negedge clock);
    resp_ready <= 1'h1;
    @(posedge clock);
    tag_seen = resp_tag;
    code     = resp_code;
    reason   = resp_reason;
    data     = resp_data;
    hint     = resp_poll_hint;
    ok       = 1'h1;
    @(negedge clock);
    resp_ready <= 1'h0;
  endtask : transact
endmodule : mgmt_host_model

// [dv/sideband_cmd_responder_test.sv]
// Testbench: scenarios for the sideband command responder
module sideband_cmd_responder_test
  import sideband_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock, rst_n, cmd_valid, cmd_ready, cmd_poll, cmd_supported, cmd_early_ok, fire;
  logic              op_start, op_busy_other, op_done, op_fail, resp_valid, resp_ready, fail_next;
  logic              event_valid, notice_valid, notice_ready, initial_state, clear_initial;
  logic [TAG_W-1:0]  cmd_tag, resp_tag, notice_tag, r_tag, cur_tag;
  logic [TYPE_W-1:0] cmd_type, op_type, resp_type, cur_kind;
  logic [CODE_W-1:0] resp_code, resp_reason, event_code, notice_code, r_code, r_reason;
  logic [DATA_W-1:0] cmd_data, op_data, op_result, link_status, resp_data, r_data;
  logic [15:0]       resp_poll_hint, r_hint;
  int                err_count, n_checks, n_start, exec_lat, cd, slow;

  always #25 clock = ~clock;

  sideband_cmd_responder #(.normal_exec_cycles(20), .async_not_ready_cycles(40), .delayed_limit_cycles(100))
    sideband_cmd_responder_i (.*);

  mgmt_host_model mgmt_host_model_i (.*);

  // ====================
  // Action engine: finishes each action after exec_lat cycles, never when 0
  always @(negedge clock) begin
    fire = (cd == 1);
    op_done <= fire && !fail_next;
    op_fail <= fire && fail_next;
    if (op_start === 1'h1) begin
      n_start++;
      cd = exec_lat;
      check("op_type", op_type, cur_kind);
      check("op_data", op_data, {cur_tag, cur_kind, cur_tag, cur_kind});
    end else if (cd > 0) begin
      cd--;
    end
  end

  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic txn(input logic [TAG_W-1:0] tag, input logic [TYPE_W-1:0] kind, input logic poll);
    logic ok;
    cur_tag  = tag;
    cur_kind = kind;
    mgmt_host_model_i.transact(tag, kind, poll, slow, ok, r_tag, r_code, r_reason, r_data, r_hint);
    if (ok !== 1'h1) begin
      err_count++;
      wrap_up();
    end
    check("resp_tag", r_tag, tag);
  endtask : txn

  task automatic pulse_clear;
    @(negedge clock);
    clear_initial <= 1'h1;
    @(negedge clock);
    clear_initial <= 1'h0;
    @(negedge clock);
    check("initial_state", initial_state, 1'h0);
  endtask : pulse_clear

  // ====================
  // Scenarios
  task automatic t_retry;
    int n;
    exec_lat  = 3;
    op_result = 32'h1111_0001;
    txn(8'h01, 8'h01, 1'h0);
    check("code", r_code, RESP_OK);
    check("data", r_data, 32'h1111_0001);
    n = n_start;
    op_result = 32'h2222_0002;
    txn(8'h01, 8'h01, 1'h0);
    check("retry data", r_data, 32'h1111_0001);
    check("retry starts", n_start, n);
    txn(8'h02, 8'h02, 1'h0);
    check("new data", r_data, 32'h2222_0002);
    txn(8'h02, 8'h02, 1'h0);
    check("replayed data", r_data, 32'h2222_0002);
    check("starts", n_start, n + 1);
  endtask : t_retry

  task automatic t_unsupp;
    int k;
    for (k = 0; k < 2; k++) begin
      cmd_supported = k[0];
      txn(8'h03 + 8'(k), k ? 8'h61 : 8'h05, 1'h0);
      check("code", r_code, RESP_UNSUPP);
      check("reason", r_reason, REASON_UNKNOWN);
    end
  endtask : t_unsupp

  task automatic t_unavail;
    op_busy_other = 1'h1;
    txn(8'h05, 8'h01, 1'h0);
    check("code", r_code, RESP_UNAVAIL);
    txn(8'h06, CMD_LINK_STATUS, 1'h0);
    check("code", r_code, RESP_OK);
    check("link data", r_data, 32'h0000_5A5A);
    op_busy_other = 1'h0;
  endtask : t_unavail

  task automatic t_delayed;
    exec_lat  = 50;
    slow      = 3;
    op_result = 32'h3333_0003;
    txn(8'h07, 8'h01, 1'h0);
    check("code", r_code, RESP_DELAYED);
    txn(8'h07, 8'h01, 1'h1);
    check("code", r_code, RESP_DELAYED);
    check("reason", r_reason, REASON_DELAYED);
    check("hint", r_hint, POLL_HINT_MS);
    // Host waits longer than the normal interval before polling again
    repeat (40) @(negedge clock);
    txn(8'h07, 8'h01, 1'h1);
    check("code", r_code, RESP_OK);
    check("data", r_data, 32'h3333_0003);
    slow = 0;
  endtask : t_delayed

  task automatic t_early;
    int k;
    int i;
    int n;
    for (k = 0; k < 2; k++) begin
      fail_next    = (k == 0);
      exec_lat     = (k == 0) ? 3 : 0;
      cmd_early_ok = 1'h1;
      txn(8'h09 + 8'(k), 8'h01, 1'h0);
      check("code", r_code, RESP_OK);
      for (i = 0; i < 45; i++) begin
        @(negedge clock);
        if (initial_state === 1'h1) break;
      end
      check("initial_state", initial_state, 1'h1);
      if (i == 45) wrap_up();
      cmd_early_ok = 1'h0;
      fail_next    = 1'h0;
      exec_lat     = 3;
      pulse_clear();
      n = n_start;
      txn(8'h09 + 8'(k), 8'h01, 1'h0);
      check("starts", n_start, n + 1);
    end
  endtask : t_early

  task automatic t_notice;
    int i;
    @(negedge clock);
    event_code  <= 16'h00A5;
    event_valid <= 1'h1;
    @(negedge clock);
    event_valid <= 1'h0;
    for (i = 0; i < 4; i++) begin
      if (notice_valid === 1'h1) break;
      @(negedge clock);
    end
    check("notice_valid", notice_valid, 1'h1);
    check("notice_tag", notice_tag, TAG_NOTICE);
    check("notice_code", notice_code, 16'h00A5);
    notice_ready <= 1'h1;
    @(negedge clock);
    notice_ready <= 1'h0;
    check("notice_valid", notice_valid, 1'h0);
  endtask : t_notice

  initial begin
    clock         = 1'h0;
    rst_n         = 1'h0;
    cmd_supported = 1'h1;
    cmd_early_ok  = 1'h0;
    op_busy_other = 1'h0;
    op_done       = 1'h0;
    op_fail       = 1'h0;
    fail_next     = 1'h0;
    op_result     = 32'h0;
    link_status   = 32'h0000_5A5A;
    event_valid   = 1'h0;
    event_code    = 16'h0;
    notice_ready  = 1'h0;
    clear_initial = 1'h0;
    repeat (6) @(negedge clock);
    rst_n = 1'h1;
    check("initial_state", initial_state, 1'h1);
    pulse_clear();
    t_retry();
    t_unsupp();
    t_unavail();
    t_delayed();
    t_early();
    t_notice();
    wrap_up();
  end
endmodule : sideband_cmd_responder_test
